// File: bench/async_shared_system_bus_tb.sv
// bench: processor end and unit end joined on one bus interface
// assumes the unit memory spans 256 words from address zero
`timescale 1ns/1ps
module async_shared_system_bus_tb;
	logic                       ref_clk;
	logic                       srst;
	logic                       arb_en;
	logic                       req_valid;
	logic                       req_ready;
	logic [ssb_pkg::ADDR_W-1:0] req_addr;
	logic [ssb_pkg::CMD_W-1:0]  req_cmd;
	logic [ssb_pkg::DATA_W-1:0] req_wdata;
	logic                       rsp_valid;
	logic [ssb_pkg::DATA_W-1:0] rdata;
	logic                       steal;
	logic                       s_valid;
	logic                       s_ready;
	logic [ssb_pkg::DATA_W-1:0] s_data;
	logic                       dma_en;
	logic                       dma_load;
	logic [ssb_pkg::ADDR_W-1:0] dma_base;
	logic                       word_done;
	logic [ssb_pkg::ADDR_W-1:0] dma_addr;
	logic                       saw_steal = 1'b0;
	int                         errors = 0;
	int                         total_checks = 0;
	int                         cyc = 0;
	int                         t_rsp = 0;
	int                         t_done = 0;
	int                         n_done = 0;
	int                         n_ssyn = 0;

	ssb_if bus_if();
	ssb_cpu_end ssb_cpu_end_i (.ref_clk_i(ref_clk), .srst_i(srst), .bus(bus_if),
		.arb_en_i(arb_en), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.req_addr_i(req_addr), .req_cmd_i(req_cmd), .req_wdata_i(req_wdata),
		.rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .steal_o(steal));
	ssb_unit_end #(.MEM_WORDS(256)) ssb_unit_end_i (.ref_clk_i(ref_clk), .srst_i(srst),
		.bus(bus_if), .s_valid_i(s_valid), .s_ready_o(s_ready), .s_data_i(s_data),
		.dma_en_i(dma_en), .dma_load_i(dma_load), .dma_base_i(dma_base),
		.word_done_o(word_done), .dma_addr_o(dma_addr));
	ssb_assertions ssb_assertions_i (.ref_clk_i(ref_clk), .srst_i(srst),
		.c_aoe(bus_if.c_aoe), .u_aoe(bus_if.u_aoe), .c_bbsy(bus_if.c_bbsy),
		.u_bbsy(bus_if.u_bbsy), .c_msyn(bus_if.c_msyn), .npr_req(bus_if.npr_req),
		.npr_gnt(bus_if.npr_gnt), .addr(bus_if.addr), .cmd(bus_if.cmd),
		.msyn(bus_if.msyn), .ssyn(bus_if.ssyn), .bbsy(bus_if.bbsy));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// cycle count doubles as the hang limit
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_of_test();
		end
	end

	// completion stamps, taken mid-cycle where outputs have settled
	always @(negedge ref_clk) begin
		if (rsp_valid === 1'b1) t_rsp = cyc;
		if (word_done === 1'b1) begin
			t_done = cyc;
			n_done++;
		end
		if (bus_if.ssyn === 1'b1) n_ssyn++;
		if (steal === 1'b1) saw_steal = 1'b1;
	end

	task end_of_test();
		if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one processor request held until taken; g opens dma grants on the same edge
	task op(input logic [1:0] c, input logic [17:0] a, input logic [15:0] d, input logic g);
		int n;
		n = 0;
		t_rsp = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_addr <= a;
		req_wdata <= d;
		if (g) arb_en <= 1'b1;
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		while (t_rsp == 0 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		chk("rsp", n < 300, 1'b1);
	endtask

	task rd(input logic [17:0] a, input logic [15:0] exp);
		op(ssb_pkg::CMD_RD, a, 16'h0000, 1'b0);
		chk("rdata", rdata, exp);
	endtask

	task push(input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_valid <= 1'b1;
		s_data <= d;
		@(negedge ref_clk);
		while (s_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		s_valid <= 1'b0;
	endtask

	// word and byte lanes, odd word address forced even
	task t_lanes();
		op(ssb_pkg::CMD_WRW, 18'h00020, 16'h1234, 1'b0);
		op(ssb_pkg::CMD_WRB, 18'h00021, 16'h00ab, 1'b0);
		rd(18'h00020, 16'hab34);
		rd(18'h00021, 16'h00ab);
		op(ssb_pkg::CMD_WRB, 18'h00020, 16'h00cd, 1'b0);
		rd(18'h00020, 16'habcd);
		op(ssb_pkg::CMD_WRW, 18'h00031, 16'h5a5a, 1'b0);
		rd(18'h00030, 16'h5a5a);
		chk("mem req", bus_if.npr_req, 1'b0);
	endtask

	// back-to-back writes may not beat the word rate
	task t_pacing();
		int t1;
		op(ssb_pkg::CMD_WRW, 18'h00050, 16'h0101, 1'b0);
		t1 = t_rsp;
		op(ssb_pkg::CMD_WRW, 18'h00052, 16'h0202, 1'b0);
		chk("pace", (t_rsp - t1) >= ssb_pkg::XFER_CYC, 1'b1);
	endtask

	// stall dma until the buffer refuses, then let it drain into memory
	task t_drain();
		int k;
		k = 0;
		@(posedge ref_clk);
		arb_en <= 1'b0;
		dma_en <= 1'b1;
		dma_load <= 1'b1;
		dma_base <= 18'h00101;
		@(posedge ref_clk);
		dma_load <= 1'b0;
		while (k < 4) begin
			@(negedge ref_clk);
			if (s_ready !== 1'b1) break;
			push(16'(16'h1111 * (k + 1)));
			k++;
		end
		chk("refuse", s_ready, 1'b0);
		chk("held", n_done, 18'h00000);
		@(posedge ref_clk);
		arb_en <= 1'b1;
		while (n_done < k && cyc < 5000) @(negedge ref_clk);
		// the address steps one edge after the last done pulse
		@(negedge ref_clk);
		chk("dma_addr", dma_addr, 18'(18'h00100 + 2 * k));
		chk("steal", saw_steal, 1'b1);
		rd(18'h00100, 16'h1111);
		rd(18'h00102, 16'h2222);
	endtask

	// pending dma word reaches the arbiter a cycle before the processor request; dma must go first
	task t_priority();
		logic [17:0] a;
		a = dma_addr;
		t_done = 0;
		@(posedge ref_clk);
		arb_en <= 1'b0;
		push(16'h7777);
		op(ssb_pkg::CMD_WRW, 18'h00060, 16'h6060, 1'b1);
		chk("dma first", t_done != 0 && t_done < t_rsp, 1'b1);
		rd(18'h00060, 16'h6060);
		rd(a, 16'h7777);
	endtask

	// unmapped address gets no answer; reset clears the hung bus
	task t_unmapped();
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd <= ssb_pkg::CMD_WRW;
		req_addr <= 18'h00400;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		n_ssyn = 0;
		t_rsp = 0;
		repeat (100) @(negedge ref_clk);
		chk("ssyn", n_ssyn, 18'h00000);
		chk("no rsp", t_rsp, 18'h00000);
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk("bbsy", bus_if.bbsy, 1'b0);
		rd(18'h00020, 16'habcd);
	endtask

	initial begin
		srst = 1'b1;
		arb_en = 1'b1;
		req_valid = 1'b0;
		req_addr = '0;
		req_cmd = '0;
		req_wdata = '0;
		s_valid = 1'b0;
		s_data = '0;
		dma_en = 1'b0;
		dma_load = 1'b0;
		dma_base = '0;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk("idle bbsy", bus_if.bbsy, 1'b0);
		chk("idle steal", steal, 1'b0);
		t_lanes();
		t_pacing();
		t_drain();
		t_priority();
		t_unmapped();
		end_of_test();
	end
endmodule // async_shared_system_bus_tb

// File: bench/ssb_assertions.sv
// checker: handshake, mastership, grant and pacing relations on the bus
// assumes the bench wires it to the interface joining both ends
`timescale 1ns/1ps
module ssb_assertions (
	input wire logic                       ref_clk_i,
	input wire logic                       srst_i,
	input wire logic                       c_aoe,
	input wire logic                       u_aoe,
	input wire logic                       c_bbsy,
	input wire logic                       u_bbsy,
	input wire logic                       c_msyn,
	input wire logic                       npr_req,
	input wire logic                       npr_gnt,
	input wire logic [ssb_pkg::ADDR_W-1:0] addr,
	input wire logic [ssb_pkg::CMD_W-1:0]  cmd,
	input wire logic                       msyn,
	input wire logic                       ssyn,
	input wire logic                       bbsy
);
	logic [5:0] gap; // cycles since the last processor sync start

	// saturating so a long idle spell never wraps into a false short gap
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) gap <= 6'h3f;
		else if ($rose(c_msyn)) gap <= 6'h00;
		else if (gap != 6'h3f) gap <= gap + 6'h01;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// mastership and handshake
	AST_ONE_MASTER: assert property (!(c_bbsy && u_bbsy))
		else $error("both ends hold the bus");
	AST_ONE_ADDR: assert property (!(c_aoe && u_aoe))
		else $error("both ends drive the address");
	AST_ANSWER_CAUSE: assert property ($rose(ssyn) |-> $past(msyn))
		else $error("slave answer without master sync");
	AST_SYNC_HOLD: assert property (msyn && !ssyn |=> msyn)
		else $error("master sync dropped before the answer");
	AST_ANSWER_DROP: assert property ($fell(msyn) |-> ##[0:2] !ssyn)
		else $error("slave answer outlives master sync");
	AST_ADDR_STEADY: assert property (msyn && $past(msyn) |-> $stable(addr) && $stable(cmd))
		else $error("address moved during sync");
	// arbitration, pacing and alignment
	AST_GRANT_FREE: assert property ($rose(npr_gnt) |-> !$past(bbsy) && !$past(msyn))
		else $error("grant while the bus was busy");
	AST_GRANT_REQ: assert property ($rose(npr_gnt) |-> npr_req)
		else $error("grant without request");
	AST_UNIT_GRANTED: assert property ($rose(u_bbsy) |-> $past(npr_gnt))
		else $error("unit took the bus ungranted");
	AST_PACE: assert property ($rose(c_msyn) |-> gap >= 6'h27)
		else $error("processor syncs closer than 40 cycles");
	AST_WORD_EVEN: assert property (msyn && cmd == ssb_pkg::CMD_WRW |-> !addr[0])
		else $error("word write at odd address");
endmodule // ssb_assertions

// File: logic/ssb_cpu_end.sv
// processor end: bus arbiter plus the processor's own bus master
// assumes a unit end on the same interface; one clock, synchronous reset
//
// Summary of operation
// R1: one fixed set of shared bus lines
// R2: every unit uses the same protocol
// R3: all registers answer at a bus address
// R4: exactly one master drives at a time
// R5: memory is slave only, never requests
// R6: mastership passes between units at run time
// R7: highest priority requester wins arbitration
// R8: processor decides when grants are given
// R9: each master signal awaits a slave answer
// R10: at most one word per 400 ns; each master paces only its own syncs, not the bus as a whole
// R11: dma units take single cycles first
// R12: processor resumes after a stolen cycle
// R13: transfers move a word or one byte
// R14: dma transfers leave processor registers alone
// R15: words even, low byte even, high odd
// R16: new grant only after bus release
// R17: unknown address gets no answer at all
`timescale 1ns/1ps
module ssb_cpu_end (
	input  wire logic                        ref_clk_i,
	input  wire logic                        srst_i,
	ssb_if.cpu_mp                            bus,
	input  wire logic                        arb_en_i,
	input  wire logic                        req_valid_i,
	output logic                             req_ready_o,
	input  wire logic [ssb_pkg::ADDR_W-1:0]  req_addr_i,
	input  wire logic [ssb_pkg::CMD_W-1:0]   req_cmd_i,
	input  wire logic [ssb_pkg::DATA_W-1:0]  req_wdata_i,
	output logic                             rsp_valid_o,
	output logic [ssb_pkg::DATA_W-1:0]       rsp_rdata_o,
	output logic                             steal_o
);
	typedef enum logic [2:0] {
		A_IDLE  = 3'h1,
		A_GRANT = 3'h2,
		A_BUSY  = 3'h4
	} ssb_arb_e;

	ssb_arb_e                   arb;
	ssb_arb_e                   next_arb;
	logic                       own_cpu;
	ssb_pkg::ssb_mst_e          state;
	ssb_pkg::ssb_mst_e          next_state;
	logic [ssb_pkg::ADDR_W-1:0] addr_q;
	logic [ssb_pkg::CMD_W-1:0]  cmd_q;
	logic [ssb_pkg::DATA_W-1:0] wdata_q;
	logic [ssb_pkg::GAP_W-1:0]  gap;

	// lowest set index is the winner; the dma slot sits at index zero
	function automatic int ssb_pick(input logic [ssb_pkg::NREQ-1:0] r);
		ssb_pick = ssb_pkg::NREQ;
		for (int i = ssb_pkg::NREQ - 1; i >= 0; i--) begin
			if (r[i])
				ssb_pick = i;
		end
	endfunction

	// request vector: dma only when the processor allows grants
	wire [ssb_pkg::NREQ-1:0] reqs = {
		state == ssb_pkg::M_ARB,
		bus.npr_req && arb_en_i // see R8
	};
	wire        bus_free = !bus.bbsy && !bus.msyn && !bus.ssyn;
	wire        any_req  = (reqs != '0);
	wire        pick_cpu = (ssb_pick(reqs) == ssb_pkg::REQ_CPU); // see R7 R11
	wire        cpu_gnt  = (arb == A_GRANT) && own_cpu;

	// arbiter: grant stands until the new master raises busy
	always_comb begin
		next_arb = arb;
		case (arb)
			A_IDLE: begin
				if (any_req && bus_free)
					next_arb = A_GRANT; // see R16
			end
			A_GRANT: begin
				if (bus.bbsy)
					next_arb = A_BUSY; // see R6
			end
			A_BUSY: begin
				if (bus_free)
					next_arb = A_IDLE; // see R16
			end
			default: next_arb = A_IDLE;
		endcase
	end

	// owner is latched at grant time so a late request cannot steal it
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			arb     <= A_IDLE;
			own_cpu <= 1'b0;
		end else begin
			arb <= next_arb;
			if (arb == A_IDLE && next_arb == A_GRANT)
				own_cpu <= pick_cpu;
		end
	end

	assign bus.npr_gnt = (arb == A_GRANT) && !own_cpu; // see R4
	assign steal_o     = (arb != A_IDLE) && !own_cpu;

	// master sequence: setup, msyn, wait ssyn, drop msyn, wait ssyn low
	always_comb begin
		next_state = state;
		case (state)
			ssb_pkg::M_IDLE: begin
				if (req_valid_i)
					next_state = ssb_pkg::M_ARB;
			end
			ssb_pkg::M_ARB: begin
				if (cpu_gnt)
					next_state = ssb_pkg::M_SETUP; // see R12
			end
			ssb_pkg::M_SETUP: begin
				if (gap == '0)
					next_state = ssb_pkg::M_SYNC; // see R10
			end
			ssb_pkg::M_SYNC: begin
				if (bus.ssyn)
					next_state = ssb_pkg::M_END; // see R9
			end
			ssb_pkg::M_END: begin
				if (!bus.ssyn)
					next_state = ssb_pkg::M_IDLE; // see R9
			end
			default: next_state = ssb_pkg::M_IDLE;
		endcase
	end

	// reads keep bit0 so an odd read selects the high lane on return
	wire [ssb_pkg::ADDR_W-1:0] req_addr_al = (req_cmd_i == ssb_pkg::CMD_RD) ? req_addr_i :
		ssb_pkg::ssb_align(req_addr_i, req_cmd_i);

	// capture the request once; a stolen cycle leaves it untouched
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			addr_q  <= '0;
			cmd_q   <= ssb_pkg::CMD_RD;
			wdata_q <= '0;
		end else if (state == ssb_pkg::M_IDLE && req_valid_i) begin
			addr_q  <= req_addr_al; // see R15
			cmd_q   <= req_cmd_i; // see R13
			wdata_q <= req_wdata_i;
		end
	end

	// byte reads return the addressed lane in the low byte
	wire [ssb_pkg::DATA_W-1:0] lane = addr_q[0] ?
		{8'h00, bus.data[ssb_pkg::DATA_W-1:ssb_pkg::BYTE_W]} : bus.data;
	wire                       byte_rd = (cmd_q == ssb_pkg::CMD_RD) && addr_q[0];
	wire                       take_rd = (state == ssb_pkg::M_SYNC) && bus.ssyn &&
		(cmd_q == ssb_pkg::CMD_RD);

	// state, pacing counter and answer registers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state       <= ssb_pkg::M_IDLE;
			gap         <= '0;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= '0;
		end else begin
			state       <= next_state;
			rsp_valid_o <= (state == ssb_pkg::M_END) && !bus.ssyn;
			if (state == ssb_pkg::M_SETUP && next_state == ssb_pkg::M_SYNC)
				gap <= ssb_pkg::GAP_W'(ssb_pkg::XFER_CYC - 1); // see R10
			else if (gap != '0)
				gap <= gap - 1'b1;
			if (take_rd)
				rsp_rdata_o <= byte_rd ? lane : bus.data; // see R15
		end
	end

	// drive the bus only while holding mastership
	wire own = (state == ssb_pkg::M_SETUP) || (state == ssb_pkg::M_SYNC) ||
		(state == ssb_pkg::M_END);
	wire wr  = (cmd_q != ssb_pkg::CMD_RD);
	assign req_ready_o = (state == ssb_pkg::M_IDLE);
	assign bus.c_bbsy  = own; // see R4
	assign bus.c_aoe   = own;
	assign bus.c_addr  = addr_q; // see R3
	assign bus.c_cmd   = cmd_q; // see R1
	assign bus.c_msyn  = (state == ssb_pkg::M_SYNC); // see R2
	assign bus.c_doe   = wr && ((state == ssb_pkg::M_SETUP) || (state == ssb_pkg::M_SYNC));
	// byte writes put the byte on the lane the address selects
	assign bus.c_data  = (cmd_q == ssb_pkg::CMD_WRB && addr_q[0]) ?
		{wdata_q[ssb_pkg::BYTE_W-1:0], wdata_q[ssb_pkg::BYTE_W-1:0]} : wdata_q;
	// dma words never pass through this module's state, see R14
endmodule // ssb_cpu_end

// File: logic/ssb_unit_end.sv
// unit end: memory slave plus a dma master fed by a stream
// assumes the processor end arbitrates; one clock, synchronous reset
`timescale 1ns/1ps
module ssb_unit_end #(
	parameter int                          MEM_WORDS = 256,
	parameter logic [ssb_pkg::ADDR_W-1:0]  BASE_ADDR = 18'h00000,
	parameter int                          DEPTH     = 2
) (
	input  wire logic                        ref_clk_i,
	input  wire logic                        srst_i,
	ssb_if.unit_mp                           bus,
	input  wire logic                        s_valid_i,
	output logic                             s_ready_o,
	input  wire logic [ssb_pkg::DATA_W-1:0]  s_data_i,
	input  wire logic                        dma_en_i,
	input  wire logic                        dma_load_i,
	input  wire logic [ssb_pkg::ADDR_W-1:0]  dma_base_i,
	output logic                             word_done_o,
	output logic [ssb_pkg::ADDR_W-1:0]       dma_addr_o
);
	localparam int IW = $clog2(MEM_WORDS);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [ssb_pkg::ADDR_W:0] SPAN = (ssb_pkg::ADDR_W+1)'(2 * MEM_WORDS);

	logic [ssb_pkg::DATA_W-1:0] mem [MEM_WORDS];
	logic [ssb_pkg::DATA_W-1:0] fifo [DEPTH];
	logic [PW-1:0]              wr_ptr;
	logic [PW-1:0]              rd_ptr;
	logic [CW-1:0]              count;
	logic [ssb_pkg::DATA_W-1:0] slv_rd;
	logic                       slv_ack;
	logic                       slv_doe;
	ssb_pkg::ssb_mst_e          state;
	ssb_pkg::ssb_mst_e          next_state;
	logic [ssb_pkg::GAP_W-1:0]  gap;

	// slave decode: only a hit inside the window ever answers
	wire [ssb_pkg::ADDR_W:0] rel = {1'b0, bus.addr} - {1'b0, BASE_ADDR};
	wire                     hit = (bus.addr >= BASE_ADDR) && (rel < SPAN); // see R17
	wire [IW-1:0]            idx = rel[IW:1]; // see R15
	wire                     start = bus.msyn && hit && !slv_ack;
	wire                     hi_lane = bus.addr[0];
	wire [ssb_pkg::DATA_W-1:0] merged = hi_lane ?
		{bus.data[ssb_pkg::BYTE_W-1:0], mem[idx][ssb_pkg::BYTE_W-1:0]} :
		{mem[idx][ssb_pkg::DATA_W-1:ssb_pkg::BYTE_W], bus.data[ssb_pkg::BYTE_W-1:0]};

	// slave: act on msyn, hold ssyn until the master drops msyn
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			slv_ack <= 1'b0;
			slv_doe <= 1'b0;
		end else if (start) begin
			slv_ack <= 1'b1; // see R9
			slv_doe <= (bus.cmd == ssb_pkg::CMD_RD);
		end else if (!bus.msyn) begin
			slv_ack <= 1'b0;
			slv_doe <= 1'b0;
		end
	end

	// memory array has no reset; byte writes touch one lane only
	always_ff @(posedge ref_clk_i) begin
		if (start && bus.cmd == ssb_pkg::CMD_WRW)
			mem[idx] <= bus.data;
		if (start && bus.cmd == ssb_pkg::CMD_WRB)
			mem[idx] <= merged; // see R13
		if (start)
			slv_rd <= mem[idx];
	end

	// two-entry buffer: the stream stalls rather than lose a word
	wire push = s_valid_i && s_ready_o;
	wire pop  = (state == ssb_pkg::M_SYNC) && bus.ssyn;
	assign s_ready_o = (count != CW'(DEPTH));
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + CW'(push) - CW'(pop);
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (push)
			fifo[wr_ptr] <= s_data_i;
	end

	// dma master: one stolen word per grant
	always_comb begin
		next_state = state;
		case (state)
			ssb_pkg::M_IDLE:  if (count != '0 && dma_en_i) next_state = ssb_pkg::M_ARB;
			ssb_pkg::M_ARB:   if (bus.npr_gnt) next_state = ssb_pkg::M_SETUP; // see R6
			ssb_pkg::M_SETUP: if (gap == '0) next_state = ssb_pkg::M_SYNC; // see R10
			ssb_pkg::M_SYNC:  if (bus.ssyn) next_state = ssb_pkg::M_END; // see R9
			ssb_pkg::M_END:   if (!bus.ssyn) next_state = ssb_pkg::M_IDLE;
			default:          next_state = ssb_pkg::M_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state       <= ssb_pkg::M_IDLE;
			gap         <= '0;
			dma_addr_o  <= '0;
			word_done_o <= 1'b0;
		end else begin
			state       <= next_state;
			word_done_o <= (state == ssb_pkg::M_END) && !bus.ssyn;
			if (state == ssb_pkg::M_SETUP && next_state == ssb_pkg::M_SYNC)
				gap <= ssb_pkg::GAP_W'(ssb_pkg::XFER_CYC - 1);
			else if (gap != '0)
				gap <= gap - 1'b1;
			if (dma_load_i)
				dma_addr_o <= ssb_pkg::ssb_align(dma_base_i, ssb_pkg::CMD_WRW);
			else if (word_done_o)
				dma_addr_o <= dma_addr_o + 18'h00002;
		end
	end

	// bus drive: master owns address while busy, slave owns read data
	wire own = (state == ssb_pkg::M_SETUP) || (state == ssb_pkg::M_SYNC) ||
		(state == ssb_pkg::M_END);
	wire mst_doe = (state == ssb_pkg::M_SETUP) || (state == ssb_pkg::M_SYNC);
	assign bus.npr_req = (state == ssb_pkg::M_ARB);
	assign bus.u_bbsy  = own; // see R4
	assign bus.u_aoe   = own;
	assign bus.u_addr  = dma_addr_o;
	assign bus.u_cmd   = ssb_pkg::CMD_WRW;
	assign bus.u_msyn  = (state == ssb_pkg::M_SYNC);
	assign bus.u_ssyn  = slv_ack;
	assign bus.u_doe   = slv_doe || mst_doe;
	assign bus.u_data  = slv_doe ? slv_rd : fifo[rd_ptr];
endmodule // ssb_unit_end

// File: shared/ssb_if.sv
// shared bus wires between the processor end and a unit end
// each end drives its own copy, address, command and data behind an enable; the wire level is resolved here
`timescale 1ns/1ps
interface ssb_if;
	logic [ssb_pkg::ADDR_W-1:0] c_addr;
	logic [ssb_pkg::ADDR_W-1:0] u_addr;
	logic [ssb_pkg::DATA_W-1:0] c_data;
	logic [ssb_pkg::DATA_W-1:0] u_data;
	logic [ssb_pkg::CMD_W-1:0]  c_cmd;
	logic [ssb_pkg::CMD_W-1:0]  u_cmd;
	logic                       c_aoe;
	logic                       u_aoe;
	logic                       c_doe;
	logic                       u_doe;
	logic                       c_msyn;
	logic                       u_msyn;
	logic                       u_ssyn;
	logic                       c_bbsy;
	logic                       u_bbsy;
	logic                       npr_req;
	logic                       npr_gnt;
	logic [ssb_pkg::ADDR_W-1:0] addr;
	logic [ssb_pkg::DATA_W-1:0] data;
	logic [ssb_pkg::CMD_W-1:0]  cmd;
	logic                       msyn;
	logic                       ssyn;
	logic                       bbsy;

	// resolved lines: enabled driver wins, processor first; wired-or for msyn and busy, ssyn from the unit only
	assign addr = c_aoe ? c_addr : (u_aoe ? u_addr : '0);
	assign cmd  = c_aoe ? c_cmd : (u_aoe ? u_cmd : '0);
	assign data = c_doe ? c_data : (u_doe ? u_data : '0);
	assign msyn = c_msyn | u_msyn;
	assign ssyn = u_ssyn;
	assign bbsy = c_bbsy | u_bbsy;

	modport cpu_mp (output c_addr, c_data, c_cmd, c_aoe, c_doe, c_msyn, c_bbsy,
		npr_gnt, input addr, data, cmd, msyn, ssyn, bbsy, npr_req);
	modport unit_mp (output u_addr, u_data, u_cmd, u_aoe, u_doe, u_msyn, u_ssyn,
		u_bbsy, npr_req, input addr, data, cmd, msyn, ssyn, bbsy, npr_gnt);
endinterface

// File: shared/ssb_pkg.sv
// shared constants, states and helpers for the shared system bus ends
// assumes one 100 MHz clock in every unit and a synchronous reset
package ssb_pkg;
	// bus widths: 18 address, 16 data, 2 command lines plus control
	localparam int ADDR_W    = 18;
	localparam int DATA_W    = 16;
	localparam int BYTE_W    = 8;
	localparam int CMD_W     = 2;
	localparam int BUS_LINES = 56; // shared line count of the full bus

	// transfer commands
	localparam logic [CMD_W-1:0] CMD_RD  = 2'h0; // read a word
	localparam logic [CMD_W-1:0] CMD_WRW = 2'h2; // write a word
	localparam logic [CMD_W-1:0] CMD_WRB = 2'h3; // write one byte

	// timing: at most one word per 400 ns, least time so round up
	localparam int CLK_MHZ   = 100;
	localparam int XFER_NS   = 400;
	localparam int XFER_CYC  = (XFER_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_W     = $clog2(XFER_CYC);

	// arbitration request slots, lower index wins
	localparam int REQ_DMA   = 0;
	localparam int REQ_CPU   = 1;
	localparam int NREQ      = 2;

	// master sequence, shared by the processor and the dma master
	typedef enum logic [4:0] {
		M_IDLE  = 5'h01,
		M_ARB   = 5'h02,
		M_SETUP = 5'h04,
		M_SYNC  = 5'h08,
		M_END   = 5'h10
	} ssb_mst_e;

	// word transfers use even addresses only
	function automatic logic [ADDR_W-1:0] ssb_align(input logic [ADDR_W-1:0] a,
		input logic [CMD_W-1:0] c);
		ssb_align = (c == CMD_WRB) ? a : {a[ADDR_W-1:1], 1'b0};
	endfunction
endpackage
